// *** src/bio_pkg.sv ***
// bio_pkg: constants for the bitwise bidirectional port
// assumes a single 8-bit port with direction and latch registers
package bio_pkg;
    localparam int         PORT_W      = 8;
    // register selects on the core-side access port
    localparam logic [0:0] SEL_LATCH   = 1'h0;
    localparam logic [0:0] SEL_DIR     = 1'h1;
    // reset values
    localparam logic [7:0] DIR_RESET   = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    // latch write operation codes: move the data, or a logical op applied to the port byte
    typedef enum logic [1:0] {
        BIO_OP_MOV,
        BIO_OP_AND,
        BIO_OP_OR,
        BIO_OP_XOR
    } bio_op_t;
endpackage

// *** src/bio_sync.sv ***
// bio_sync: three-stage synchroniser for the port pins
// assumes pins are asynchronous to MCLK
`timescale 1ns/10ps
module bio_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         MCLK,
    input  wire logic         RST,
    // raw and settled levels
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    if (W < 1) begin
        $error("bio_sync: width must be at least one");
    end

    // a bit changes only once stages two and three agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// *** src/bio_port.sv ***
// bio_port: 8-bit port with per-bit direction and output latch
// assumes the core issues one access per cycle on the access port;
// pins are split into input, output and output enable
`timescale 1ns/10ps
module bio_port #(
    parameter int W = 8
) (
    // clock, reset and hardware stop
    input  wire logic         MCLK,
    input  wire logic         RST,
    input  wire logic         HW_STOP,
    // core access port
    input  wire logic         ACC_EN,
    input  wire logic         ACC_WR,
    input  wire logic [0:0]   ACC_SEL,
    input  wire logic [1:0]   ACC_OP,
    input  wire logic [W-1:0] ACC_WDATA,
    output logic [W-1:0]      ACC_RDATA,
    // bit test
    input  wire logic [2:0]   TEST_BIT,
    output logic              TEST_LEVEL,
    // pins
    input  wire logic [W-1:0] PIN_I,
    output logic [W-1:0]      PIN_O,
    output logic [W-1:0]      PIN_OE
);
    // only the eight-pin port is served
    if (W != bio_pkg::PORT_W) begin
        $error("bio_port: width must be 8");
    end

    logic [W-1:0] direction_select_reg_q, direction_select_reg_d;
    logic [W-1:0] first_port_latch_q, first_port_latch_d;
    logic [W-1:0] rdata_q, rdata_d;
    logic         test_q, test_d;
    logic [W-1:0] pin_s;
    logic [W-1:0] port_view;

    bio_sync #(.W(W)) u_sync (
        .MCLK (MCLK),
        .RST  (RST),
        .din  (PIN_I),
        .dout (pin_s)
    );

    // mixes pin levels and latch by direction
    function automatic logic [W-1:0] mix_view(
        input logic [W-1:0] dir,
        input logic [W-1:0] pins,
        input logic [W-1:0] lat
    );
        mix_view = (dir & pins) | (~dir & lat);
    endfunction

    assign port_view = mix_view(direction_select_reg_q, pin_s,
                                first_port_latch_q);

    // logical ops act on the read view, so an input bit's latch picks
    // up its pin level, as a byte read, modify and write back would
    always_comb begin
        direction_select_reg_d = direction_select_reg_q;
        first_port_latch_d     = first_port_latch_q;
        if (ACC_EN && ACC_WR) begin
            if (ACC_SEL == bio_pkg::SEL_DIR) begin
                direction_select_reg_d = ACC_WDATA;
            end else begin
                case (bio_pkg::bio_op_t'(ACC_OP))
                    bio_pkg::BIO_OP_MOV: first_port_latch_d = ACC_WDATA;
                    bio_pkg::BIO_OP_AND:
                        first_port_latch_d = port_view & ACC_WDATA;
                    bio_pkg::BIO_OP_OR:
                        first_port_latch_d = port_view | ACC_WDATA;
                    bio_pkg::BIO_OP_XOR:
                        first_port_latch_d = port_view ^ ACC_WDATA;
                    default: first_port_latch_d = ACC_WDATA;
                endcase
            end
        end
        if (HW_STOP) begin
            direction_select_reg_d = bio_pkg::DIR_RESET;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            direction_select_reg_q <= bio_pkg::DIR_RESET;
            first_port_latch_q     <= bio_pkg::LATCH_RESET;
        end else begin
            direction_select_reg_q <= direction_select_reg_d;
            first_port_latch_q     <= first_port_latch_d;
        end
    end

    // read path: data stand until the next read
    always_comb begin
        rdata_d = rdata_q;
        test_d  = port_view[TEST_BIT];
        if (ACC_EN && !ACC_WR) begin
            rdata_d = (ACC_SEL == bio_pkg::SEL_DIR) ?
                      direction_select_reg_q : port_view;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rdata_q <= '0;
            test_q  <= 1'h0;
        end else begin
            rdata_q <= rdata_d;
            test_q  <= test_d;
        end
    end

    assign PIN_O      = first_port_latch_q;
    assign PIN_OE     = ~direction_select_reg_q;
    assign ACC_RDATA  = rdata_q;
    assign TEST_LEVEL = test_q;

    // all checks run on the one clock and rest while reset is high
    default clocking cb_main @(posedge MCLK);
    endclocking
    default disable iff (RST);

    chk_oe_dir: assert property (
        (ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_DIR && !HW_STOP)
        |=> PIN_OE == ~$past(ACC_WDATA))
        else $error("output enable does not follow direction");
    chk_stop_dir: assert property (
        HW_STOP |=> PIN_OE == 8'h00)
        else $error("hardware stop left a driver on");
    chk_reset_dir: assert property (
        $past(RST) |-> PIN_OE == 8'h00)
        else $error("driver on right after reset");
    chk_read_mix: assert property (
        (ACC_EN && !ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH)
        |=> ACC_RDATA == $past(port_view))
        else $error("port read data wrong");
    // read data stand until next read
    chk_rdata_hold: assert property (
        !(ACC_EN && !ACC_WR) |=> $stable(ACC_RDATA))
        else $error("read data changed without a read");
    chk_write_all: assert property (
        (ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH
         && ACC_OP == 2'h0) |=> first_port_latch_q == $past(ACC_WDATA))
        else $error("latch not written");
    chk_in_masked: assert property (
        (ACC_EN && !ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH)
        |=> ((ACC_RDATA ^ $past(pin_s)) & $past(direction_select_reg_q))
            == 8'h00)
        else $error("latch leaked on input bit");
    chk_latch_hold: assert property (
        !(ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH)
        |=> $stable(first_port_latch_q))
        else $error("latch changed without write");
    // and works on the read byte
    chk_and_rmw: assert property (
        (ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH
         && ACC_OP == 2'h1)
        |=> first_port_latch_q == ($past(port_view) & $past(ACC_WDATA)))
        else $error("and did not work on the port byte");
    chk_or_sets: assert property (
        (ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_LATCH
         && ACC_OP == 2'h2) |=> ((first_port_latch_q & $past(ACC_WDATA))
         == $past(ACC_WDATA)))
        else $error("or did not set bits");
    chk_bit_test: assert property (
        1'h1 |=> TEST_LEVEL == $past(port_view[TEST_BIT]))
        else $error("bit test wrong");
    chk_dir_write: assert property (
        (ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_DIR && !HW_STOP)
        |=> direction_select_reg_q == $past(ACC_WDATA))
        else $error("direction not written");
    chk_dir_hold: assert property (
        !(ACC_EN && ACC_WR && ACC_SEL == bio_pkg::SEL_DIR) && !HW_STOP
        |=> $stable(direction_select_reg_q))
        else $error("direction changed without write");
    chk_reset_latch: assert property (
        $past(RST) |-> PIN_O == bio_pkg::LATCH_RESET)
        else $error("latch not cleared by reset");

    cov_mixed: cover property (direction_select_reg_q == 8'h0f);
    cov_stop: cover property (HW_STOP && PIN_OE != 8'h00);
    cov_and: cover property (ACC_EN && ACC_WR && ACC_OP == 2'h1);
    // a read followed by a write, the read-modify-write pattern
    cov_rmw_pair: cover property (
        (ACC_EN && !ACC_WR) ##2 (ACC_EN && ACC_WR));
endmodule

// *** verification/bio_board.sv ***
// bio_board: board side of the eight port pins
// assumes each pin is driven by the port only while its enable is high
`timescale 1ns/10ps
module bio_board (
    // port side
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    // board drive for released pins
    input  wire logic [7:0] ext,
    output logic [7:0]      pin
);
    // released pins follow the board, never the stale latch
    assign pin = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

// *** verification/bitwise_bidir_io_port_tb.sv ***
// testbench for the bitwise bidirectional port
// assumes fixed access latencies; pin view settles within six edges
`timescale 1ns/10ps
module bitwise_bidir_io_port_tb;
    logic       MCLK = 0, RST = 1, HW_STOP = 0, ACC_EN = 0, ACC_WR = 0;
    logic [0:0] ACC_SEL = '0;
    logic [1:0] ACC_OP = '0;
    logic [7:0] ACC_WDATA = '0, ext = 8'h00, pin, ACC_RDATA, PIN_O, PIN_OE;
    logic [2:0] TEST_BIT = '0;
    logic       TEST_LEVEL;
    int         n_errors = 0, checks = 0;
    always #4 MCLK = ~MCLK;
    bio_port i_dut (.MCLK(MCLK), .RST(RST), .HW_STOP(HW_STOP),
        .ACC_EN(ACC_EN), .ACC_WR(ACC_WR), .ACC_SEL(ACC_SEL), .ACC_OP(ACC_OP),
        .ACC_WDATA(ACC_WDATA), .ACC_RDATA(ACC_RDATA), .TEST_BIT(TEST_BIT),
        .TEST_LEVEL(TEST_LEVEL), .PIN_I(pin), .PIN_O(PIN_O), .PIN_OE(PIN_OE));
    bio_board i_board (.pin_o(PIN_O), .pin_oe(PIN_OE), .ext(ext), .pin(pin));
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task acc(input logic w, input logic s, input logic [1:0] o,
             input logic [7:0] d);
        ACC_EN = 1;
        ACC_WR = w;
        ACC_SEL = s;
        ACC_OP = o;
        ACC_WDATA = d;
        @(posedge MCLK);
        #1 ACC_EN = 0;
        // idle edge, so a following call never lowers and raises at once
        @(posedge MCLK);
        #1;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task t_reset;
        chk(PIN_OE, 8'h00, "oe after reset");
        chk(PIN_O, 8'h00, "latch after reset");
        acc(0, 1, 0, 8'h00);
        chk(ACC_RDATA, 8'hff, "dir after reset");
        $display("test reset done");
    endtask
    task t_mixed;
        ext = 8'h5a;
        acc(1, 1, 0, 8'h0f);
        acc(1, 0, 0, 8'hc3);
        cyc(6);
        chk(PIN_OE, 8'hf0, "enables");
        chk(PIN_O, 8'hc3, "latch all bits");
        chk(pin, 8'hca, "pin wire");
        acc(0, 0, 0, 8'h00);
        chk(ACC_RDATA, 8'hca, "mixed read");
        $display("test mixed done");
    endtask
    task t_logic;
        acc(1, 0, 2'h1, 8'hf0);
        chk(PIN_O, 8'hc0, "and");
        acc(1, 0, 2'h2, 8'h05);
        chk(PIN_O, 8'hcf, "or");
        acc(1, 0, 2'h3, 8'hff);
        chk(PIN_O, 8'h35, "xor");
        ext = 8'ha9;
        cyc(8);
        chk(PIN_O, 8'h35, "latch holds");
        $display("test logic done");
    endtask
    task t_test;
        logic [7:0] v;
        v = 8'h39;
        for (int i = 0; i < 8; i++) begin
            TEST_BIT = i[2:0];
            cyc(1);
            chk({7'h00, TEST_LEVEL}, {7'h00, v[i]}, "bit test");
        end
        $display("test bit done");
    endtask
    task t_stop;
        HW_STOP = 1;
        acc(1, 1, 0, 8'h00);
        HW_STOP = 0;
        cyc(1);
        chk(PIN_OE, 8'h00, "stop oe");
        chk(PIN_O, 8'h35, "stop latch");
        acc(0, 1, 0, 8'h00);
        chk(ACC_RDATA, 8'hff, "stop dir");
        acc(1, 1, 0, 8'h0f);
        chk(PIN_OE, 8'hf0, "drivers before reset");
        RST = 1;
        cyc(1);
        RST = 0;
        chk(PIN_OE, 8'h00, "second reset oe");
        chk(PIN_O, 8'h00, "second reset");
        $display("test stop done");
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        RST = 0;
        t_reset();
        t_mixed();
        t_logic();
        t_test();
        t_stop();
        close_out();
    end
endmodule
